/* File: rtc_modulo_counter.v */
// top of the modulo tick counter: apb register slave, source selection,
// 8-bit tick counter with compare, periodic flag and interrupt request.
// assumes the three source clocks and debug_halt are synchronous to core_clk
// and that a source toggles slower than core_clk.
//
// How it works
// (RULE1) 8-bit up-counter compared against an 8-bit writable compare limit.
// (RULE2) compare limit accepts any value from 0x00 to 0xFF.
// (RULE3) counter advances per prescaler tick, wraps to zero on match, continues.
// (RULE4) on match the count clears and the flag sets in one step.
// (RULE5) flag sets when the count moves from the limit to zero.
// (RULE6) limit zero sets the flag on every prescaler tick.
// (RULE7) any compare limit write clears prescaler and counter.
// (RULE8) reset: counter stopped at zero, limit zero, prescaler off, low power source.
// (RULE9) divider select zero keeps prescaler off; software writes nonzero to start.
// (RULE10) source code 00 low power, 01 external, 10 or 11 internal reference.
// (RULE11) writing a different source select clears prescaler and counter.
// (RULE12) writing a different divider select clears prescaler and counter.
// (RULE13) divide ratio chosen by divider select and low source select bit.
// (RULE14) interrupt request while flag and irq enable are both set.
// (RULE15) writing one to the flag bit clears flag and request.
// (RULE16) binary and decimal divide value tables for each low source bit.
// (RULE17) counter readable any time, writes to it ignored.
// (RULE18) writing zero to the flag bit leaves it unchanged.
// (RULE19) debug halt freezes counting; resumes from held value.
// (RULE20) sources sampled in core_clk so resets and flag updates happen once.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "rtc_defs.vh"

module rtc_modulo_counter (
  input wire core_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire low_power_osc_clock,
  input wire external_ref_clock,
  input wire internal_ref_clock,
  input wire debug_halt,
  output reg periodic_irq
);

  // control and status state
  reg [7:0] compare_limit;
  reg [7:0] tick_count; // RULE1
  reg [1:0] source_select;
  reg [3:0] divider_select;
  reg periodic_irq_enable;
  reg periodic_flag;
  reg low_prev;
  reg ext_prev;
  reg int_prev;
  reg held_tick;

  // combinational helpers
  reg source_rise;
  reg [31:0] read_value;
  reg mapped;
  reg next_flag;
  reg next_enable;
  wire prescale_tick;
  wire access_done;
  wire wr_status;
  wire wr_compare;
  wire new_source;
  wire new_divider;
  wire clear_all;
  wire source_edge;
  wire count_step;
  wire wrap;

  // ---------------- apb slave ----------------
  // no wait state: data is latched in the setup cycle and pready rises in
  // the first access cycle, so every transfer takes exactly two cycles
  assign access_done = psel & penable & pready;
  assign wr_status = access_done & pwrite & (paddr == `OFS_STATUS_CONTROL);
  assign wr_compare = access_done & pwrite & (paddr == `OFS_COMPARE_LIMIT);

  always @* begin
    read_value = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OFS_STATUS_CONTROL: begin
        read_value[`BIT_PERIODIC_FLAG] = periodic_flag;
        read_value[`SRC_SEL_HI:`SRC_SEL_LO] = source_select;
        read_value[`BIT_PERIODIC_IRQ_ENABLE] = periodic_irq_enable;
        read_value[`DIV_SEL_HI:`DIV_SEL_LO] = divider_select;
      end
      `OFS_TICK_COUNT: begin
        read_value[7:0] = tick_count; // RULE17
      end
      `OFS_COMPARE_LIMIT: begin
        read_value[7:0] = compare_limit;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access_done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : read_value;
      pslverr <= ~mapped;
    end
  end

  // ---------------- configuration ----------------
  // a write of the same source or divider code keeps the running count
  assign new_source = wr_status &&
    (pwdata[`SRC_SEL_HI:`SRC_SEL_LO] != source_select); // RULE11
  assign new_divider = wr_status &&
    (pwdata[`DIV_SEL_HI:`DIV_SEL_LO] != divider_select); // RULE12
  assign clear_all = wr_compare | new_source | new_divider; // RULE7

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      compare_limit <= `RST_COMPARE_LIMIT; // RULE8
      source_select <= `RST_SOURCE_SELECT;
      divider_select <= `RST_DIVIDER_SELECT;
      periodic_irq_enable <= 1'b0;
    end else begin
      if (wr_compare) begin
        compare_limit <= pwdata[7:0]; // RULE2
      end
      if (wr_status) begin
        source_select <= pwdata[`SRC_SEL_HI:`SRC_SEL_LO];
        divider_select <= pwdata[`DIV_SEL_HI:`DIV_SEL_LO]; // RULE9
        periodic_irq_enable <= pwdata[`BIT_PERIODIC_IRQ_ENABLE];
      end
    end
  end

  // ---------------- source selection ----------------
  // each source keeps its own previous sample, so a switch compares the new
  // source with its own history and cannot invent an edge;
  // sources faster than half core_clk alias
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      low_prev <= 1'b0;
      ext_prev <= 1'b0;
      int_prev <= 1'b0;
    end else begin
      low_prev <= low_power_osc_clock; // RULE20
      ext_prev <= external_ref_clock;
      int_prev <= internal_ref_clock;
    end
  end

  always @* begin
    case (source_select) // RULE10
      `SRC_LOW_POWER: source_rise = low_power_osc_clock & ~low_prev;
      `SRC_EXTERNAL: source_rise = external_ref_clock & ~ext_prev;
      default: source_rise = internal_ref_clock & ~int_prev;
    endcase
  end

  // a halted debugger freezes the prescaler as well as the counter
  assign source_edge = source_rise & ~debug_halt; // RULE19

  rtc_prescaler u_prescaler (
    .core_clk(core_clk),
    .reset(reset),
    .clear(clear_all),
    .source_edge(source_edge),
    .low_select(source_select[0]),
    .divider_select(divider_select),
    .tick(prescale_tick)
  );

  // ---------------- tick counter ----------------
  // a tick already in flight when the halt begins waits here, so the
  // prescaler period it closed is not lost and counting resumes in step
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      held_tick <= 1'b0;
    end else if (clear_all || count_step) begin
      held_tick <= 1'b0;
    end else if (prescale_tick && debug_halt) begin
      held_tick <= 1'b1; // RULE19
    end
  end

  assign count_step = (prescale_tick | held_tick) & ~debug_halt & ~clear_all; // RULE19
  assign wrap = count_step & (tick_count == compare_limit); // RULE6

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_count <= `RST_TICK_COUNT; // RULE8
    end else if (clear_all) begin
      tick_count <= `RST_TICK_COUNT; // RULE7
    end else if (wrap) begin
      tick_count <= `RST_TICK_COUNT; // RULE4
    end else if (count_step) begin
      tick_count <= tick_count + 8'h01; // RULE3
    end
  end

  // ---------------- flag and request ----------------
  // a new wrap in the clearing cycle wins, so no period is lost
  always @* begin
    next_flag = periodic_flag;
    if (access_done && pwrite && paddr == `OFS_STATUS_CONTROL &&
        pwdata[`BIT_PERIODIC_FLAG]) begin
      next_flag = 1'b0; // RULE15
    end
    if (wrap) begin
      next_flag = 1'b1; // RULE5
    end
    next_enable = wr_status ? pwdata[`BIT_PERIODIC_IRQ_ENABLE] : periodic_irq_enable;
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      periodic_flag <= 1'b0;
      periodic_irq <= 1'b0;
    end else begin
      periodic_flag <= next_flag; // RULE18
      periodic_irq <= next_flag & next_enable; // RULE14
    end
  end

endmodule // rtc_modulo_counter

/* File: rtc_defs.vh */
// constants of the modulo tick counter: register offsets, field positions,
// reset values and the prescaler divide values.
// assumes inclusion by bare name from the design files.
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// byte offsets on the apb bus
`define OFS_STATUS_CONTROL 12'h000
`define OFS_TICK_COUNT 12'h004
`define OFS_COMPARE_LIMIT 12'h008

// counter_status_control field positions
`define BIT_PERIODIC_FLAG 7
`define SRC_SEL_HI 6
`define SRC_SEL_LO 5
`define BIT_PERIODIC_IRQ_ENABLE 4
`define DIV_SEL_HI 3
`define DIV_SEL_LO 0

// reset values
`define RST_COMPARE_LIMIT 8'h00
`define RST_TICK_COUNT 8'h00
`define RST_SOURCE_SELECT 2'h0
`define RST_DIVIDER_SELECT 4'h0

// source select codes, code 2 and 3 both pick the internal reference
`define SRC_LOW_POWER 2'h0
`define SRC_EXTERNAL 2'h1

// divider select code that keeps the prescaler off
`define DIV_OFF 4'h0

// prescaler count width, large enough for the biggest divide value
`define DIV_W 18

// divide values with the low source select bit at 0
`define DIV0_1 18'h0_0008
`define DIV0_2 18'h0_0020
`define DIV0_3 18'h0_0040
`define DIV0_4 18'h0_0080
`define DIV0_5 18'h0_0100
`define DIV0_6 18'h0_0200
`define DIV0_7 18'h0_0400
`define DIV0_8 18'h0_0001
`define DIV0_9 18'h0_0002
`define DIV0_10 18'h0_0004
`define DIV0_11 18'h0_000a
`define DIV0_12 18'h0_0010
`define DIV0_13 18'h0_0064
`define DIV0_14 18'h0_01f4
`define DIV0_15 18'h0_03e8

// divide values with the low source select bit at 1
`define DIV1_1 18'h0_0400
`define DIV1_2 18'h0_0800
`define DIV1_3 18'h0_1000
`define DIV1_4 18'h0_2000
`define DIV1_5 18'h0_4000
`define DIV1_6 18'h0_8000
`define DIV1_7 18'h1_0000
`define DIV1_8 18'h0_03e8
`define DIV1_9 18'h0_07d0
`define DIV1_10 18'h0_1388
`define DIV1_11 18'h0_2710
`define DIV1_12 18'h0_4e20
`define DIV1_13 18'h0_c350
`define DIV1_14 18'h1_86a0
`define DIV1_15 18'h3_0d40

`endif

/* File: rtc_prescaler.v */
// prescaler: counts rising edges of the selected source and gives one
// tick pulse every divide value edges.
// assumes source_edge is a one-cycle pulse in the core_clk domain.
`timescale 1ns/1ps
`include "rtc_defs.vh"

module rtc_prescaler (
  input wire core_clk,
  input wire reset,
  input wire clear,
  input wire source_edge,
  input wire low_select,
  input wire [3:0] divider_select,
  output reg tick
);

  reg [`DIV_W-1:0] edge_count;
  reg [`DIV_W-1:0] divide_value;

  always @* begin
    divide_value = `DIV0_8;
    case ({low_select, divider_select}) // RULE13
      5'h01: divide_value = `DIV0_1; // RULE16
      5'h02: divide_value = `DIV0_2;
      5'h03: divide_value = `DIV0_3;
      5'h04: divide_value = `DIV0_4;
      5'h05: divide_value = `DIV0_5;
      5'h06: divide_value = `DIV0_6;
      5'h07: divide_value = `DIV0_7;
      5'h08: divide_value = `DIV0_8;
      5'h09: divide_value = `DIV0_9;
      5'h0a: divide_value = `DIV0_10;
      5'h0b: divide_value = `DIV0_11;
      5'h0c: divide_value = `DIV0_12;
      5'h0d: divide_value = `DIV0_13;
      5'h0e: divide_value = `DIV0_14;
      5'h0f: divide_value = `DIV0_15;
      5'h11: divide_value = `DIV1_1; // RULE16
      5'h12: divide_value = `DIV1_2;
      5'h13: divide_value = `DIV1_3;
      5'h14: divide_value = `DIV1_4;
      5'h15: divide_value = `DIV1_5;
      5'h16: divide_value = `DIV1_6;
      5'h17: divide_value = `DIV1_7;
      5'h18: divide_value = `DIV1_8;
      5'h19: divide_value = `DIV1_9;
      5'h1a: divide_value = `DIV1_10;
      5'h1b: divide_value = `DIV1_11;
      5'h1c: divide_value = `DIV1_12;
      5'h1d: divide_value = `DIV1_13;
      5'h1e: divide_value = `DIV1_14;
      5'h1f: divide_value = `DIV1_15;
      default: divide_value = `DIV0_8;
    endcase
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      edge_count <= {`DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (clear || divider_select == `DIV_OFF) begin
      edge_count <= {`DIV_W{1'b0}}; // RULE9
      tick <= 1'b0;
    end else if (source_edge) begin
      if (edge_count == divide_value - {{(`DIV_W-1){1'b0}}, 1'b1}) begin
        edge_count <= {`DIV_W{1'b0}};
        tick <= 1'b1;
      end else begin
        edge_count <= edge_count + {{(`DIV_W-1){1'b0}}, 1'b1};
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule // rtc_prescaler

/* File: rtc_modulo_counter_sva.sv */
// checker for the modulo tick counter: apb timing and interrupt request.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_modulo_counter_sva (
  input wire core_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire debug_halt,
  input wire periodic_irq
);
  wire mapped = paddr == `OFS_STATUS_CONTROL || paddr == `OFS_TICK_COUNT ||
    paddr == `OFS_COMPARE_LIMIT;
  wire status_wr = psel && penable && pready && pwrite && paddr == `OFS_STATUS_CONTROL;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  chk_ready_after_setup: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (setup_s ##1 access_s |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  chk_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  chk_irq_fall_cause: assert property ($fell(periodic_irq) |-> $past(status_wr))
    else $error("interrupt request fell without a status write");
  chk_irq_disable: assert property (status_wr && !pwdata[4] |=> !periodic_irq)
    else $error("interrupt request high with enable cleared");
  chk_halt_hold: assert property (debug_halt && !status_wr |=> $stable(periodic_irq))
    else $error("interrupt request changed during halt");
endmodule // rtc_modulo_counter_sva
bind rtc_modulo_counter rtc_modulo_counter_sva u_chk (.core_clk, .reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .debug_halt, .periodic_irq);

/* File: rtc_modulo_counter_tb.sv */
// self-checking bench for the modulo tick counter over apb.
// assumes sources are slow levels driven here, four core clocks a period.
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_modulo_counter_tb;
  logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, debug_halt = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [2:0] src = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, periodic_irq;
  int n_mismatch = 0, check_count = 0, sel;
  int div_of [9] = '{8, 32, 64, 128, 1, 2, 4, 10, 16};
  logic [3:0] code_of [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  rtc_modulo_counter DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_osc_clock(src[0]), .external_ref_clock(src[1]),
    .internal_ref_clock(src[2]), .debug_halt(debug_halt), .periodic_irq(periodic_irq));
  initial forever #2.5 core_clk = ~core_clk;
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait: a slave that never answers is reported, not hung on
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 16);
    if (k >= 16) chk("pready_wait", 1, 0);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h00_0000, d});
    chk("write_err", 0, {31'h0000_0000, err});
  endtask
  task rc(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(0, a, 32'h0000_0000);
    chk(nm, {24'h00_0000, e}, rd);
  endtask
  task irq_chk(input logic e);
    #1 chk("irq", {31'h0000_0000, e}, {31'h0000_0000, periodic_irq});
  endtask
  task pulses(input int b, input int n);
    repeat (n) begin
      src[b] <= 1;
      repeat (2) @(posedge core_clk);
      src[b] <= 0;
      repeat (2) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 0;
    rc(`OFS_STATUS_CONTROL, 8'h00, "status");
    rc(`OFS_TICK_COUNT, 8'h00, "count");
    rc(`OFS_COMPARE_LIMIT, 8'h00, "limit");
    apb(0, 12'h00c, 32'h0000_0000);
    chk("unmapped_err", 1, {31'h0000_0000, err});
    pulses(0, 3);
    rc(`OFS_TICK_COUNT, 8'h00, "count_off");
    $display("test reset done");
    wr(`OFS_STATUS_CONTROL, 8'h18);
    pulses(0, 1);
    rc(`OFS_STATUS_CONTROL, 8'h98, "flag_zero_limit");
    irq_chk(1);
    wr(`OFS_STATUS_CONTROL, 8'h18);
    rc(`OFS_STATUS_CONTROL, 8'h98, "flag_kept");
    wr(`OFS_STATUS_CONTROL, 8'h98);
    rc(`OFS_STATUS_CONTROL, 8'h18, "flag_clear");
    irq_chk(0);
    wr(`OFS_STATUS_CONTROL, 8'h08);
    pulses(0, 1);
    irq_chk(0);
    rc(`OFS_STATUS_CONTROL, 8'h88, "flag_no_irq");
    wr(`OFS_STATUS_CONTROL, 8'h88);
    $display("test flag done");
    wr(`OFS_COMPARE_LIMIT, 8'h03);
    pulses(0, 3);
    rc(`OFS_TICK_COUNT, 8'h03, "count_at_limit");
    rc(`OFS_STATUS_CONTROL, 8'h08, "no_flag_yet");
    pulses(0, 1);
    rc(`OFS_TICK_COUNT, 8'h00, "wrap");
    rc(`OFS_STATUS_CONTROL, 8'h88, "flag_wrap");
    wr(`OFS_TICK_COUNT, 8'h55);
    rc(`OFS_TICK_COUNT, 8'h00, "count_ro");
    pulses(0, 2);
    wr(`OFS_COMPARE_LIMIT, 8'h03);
    rc(`OFS_TICK_COUNT, 8'h00, "limit_clear");
    wr(`OFS_COMPARE_LIMIT, 8'hff);
    rc(`OFS_COMPARE_LIMIT, 8'hff, "limit_max");
    pulses(0, 2);
    wr(`OFS_STATUS_CONTROL, 8'h08);
    rc(`OFS_TICK_COUNT, 8'h02, "same_value");
    wr(`OFS_STATUS_CONTROL, 8'h09);
    rc(`OFS_TICK_COUNT, 8'h00, "div_change");
    pulses(0, 3);
    rc(`OFS_TICK_COUNT, 8'h01, "div_two");
    @(posedge core_clk) debug_halt <= 1;
    pulses(0, 4);
    rc(`OFS_TICK_COUNT, 8'h01, "halt_hold");
    @(posedge core_clk) debug_halt <= 0;
    pulses(0, 1);
    rc(`OFS_TICK_COUNT, 8'h02, "halt_resume");
    wr(`OFS_STATUS_CONTROL, 8'h00);
    pulses(0, 2);
    rc(`OFS_TICK_COUNT, 8'h00, "div_off");
    $display("test counting done");
    // a new source always clears, so one count proves the clear and the ratio
    for (int s = 0; s < 4; s++) begin
      sel = s > 1 ? 2 : s;
      wr(`OFS_STATUS_CONTROL, {1'b0, 2'(s), 5'h08});
      pulses((sel + 1) % 3, 2);
      pulses(sel, s[0] ? 1000 : 1);
      rc(`OFS_TICK_COUNT, 8'h01, "source_count");
    end
    $display("test sources done");
    // each code gets exactly its divide value in edges: one tick, count one
    for (int i = 0; i < 9; i++) begin
      wr(`OFS_STATUS_CONTROL, {4'h0, code_of[i]});
      pulses(0, div_of[i]);
      rc(`OFS_TICK_COUNT, 8'h01, "divide_table");
    end
    $display("test divide table done");
    @(posedge core_clk) reset <= 1;
    repeat (2) @(posedge core_clk);
    reset <= 0;
    rc(`OFS_STATUS_CONTROL, 8'h00, "status_rerun");
    rc(`OFS_COMPARE_LIMIT, 8'h00, "limit_rerun");
    pulses(0, 2);
    rc(`OFS_TICK_COUNT, 8'h00, "count_rerun");
    $display("test second reset done");
    complete_run;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    complete_run;
  end
endmodule // rtc_modulo_counter_tb
